// file: return_rotate_reset_ops_regs.vh
// Register offsets, field positions, reset values, opcodes and timing counts.
`ifndef RETURN_ROTATE_RESET_OPS_REGS_VH
`define RETURN_ROTATE_RESET_OPS_REGS_VH

// Register byte offsets on the Avalon-MM slave.
`define OFS_INSTR          8'h00
`define OFS_ACCUM          8'h04
`define OFS_STATUS         8'h08
`define OFS_INTCTL         8'h0c
`define OFS_PWRCTL         8'h10
`define OFS_PC             8'h14
`define OFS_STACK          8'h18
`define OFS_PTR0           8'h1c
`define OFS_PTR1           8'h20
`define OFS_FILE_ADDR      8'h24
`define OFS_FILE_DATA      8'h28
`define OFS_CYCLES         8'h2c

// Field positions.
`define CARRY_BIT          0
`define IRQ_ENABLE_BIT     7
`define RESET_FLAG_BIT     2

// Reset values.
`define RESET_FLAG_RESET   1'b1
`define IRQ_ENABLE_RESET   1'b0

// Instruction encodings.
`define OP_NOP             16'h0000
`define OP_RESET           16'h0001
`define OP_INT_RETURN      16'h0009
`define OP_RETURN_BASE     16'h0012
`define OP_LIT_RETURN_HI   8'h0c
`define OP_ROTATE_HI       6'h0d
`define OP_PTR_BASE        14'h0008

// Decoded operation classes.
`define CLS_NOP            3'd0
`define CLS_RESET          3'd1
`define CLS_INT_RETURN     3'd2
`define CLS_LIT_RETURN     3'd3
`define CLS_RETURN         3'd4
`define CLS_ROTATE         3'd5
`define CLS_PTR            3'd6
`define CLS_OTHER          3'd7

// Timing and sizes.
`define CYCLE_DIV          2'd3
`define STACK_DEPTH        16
`define FILE_CELLS         128

`endif

// file: cycle_divider.v
// Divider that turns the system clock into one-cycle instruction-cycle enables.
`include "return_rotate_reset_ops_regs.vh"

module cycle_divider
(
  input  wire       clk_sys,
  input  wire       reset_n,
  output reg        cycle_tick
);

  reg [1:0] count;

  // One instruction cycle is four system clocks; the tick marks its last clock.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count      <= 2'h0;
      cycle_tick <= 1'b0;
    end
    else
    begin
      count      <= count + 2'h1;
      cycle_tick <= (count == (`CYCLE_DIV - 2'd1));
    end
  end

endmodule // cycle_divider

// file: return_stack.v
// Hardware return stack of sixteen program-counter entries.
`include "return_rotate_reset_ops_regs.vh"

module return_stack
(
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        clear,
  input  wire        push,
  input  wire        pop,
  input  wire [14:0] push_value,
  output wire [14:0] stack_top,
  output reg  [4:0]  depth
);

  reg [14:0] entry [0:`STACK_DEPTH-1];
  integer    i;

  // Top of stack reads zero when empty, so a stray return lands at address zero.
  assign stack_top = (depth == 5'h00) ? 15'h0000 : entry[depth[3:0] - 4'h1];

  // A push onto a full stack is dropped; a pop from an empty one leaves it empty.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      depth <= 5'h00;
      for (i = 0; i < `STACK_DEPTH; i = i + 1)
        entry[i] <= 15'h0000;
    end
    else if (clear)
    begin
      depth <= 5'h00;
      for (i = 0; i < `STACK_DEPTH; i = i + 1)
        entry[i] <= 15'h0000;
    end
    else if (pop && depth != 5'h00)
      depth <= depth - 5'h01;
    else if (push && depth != 5'h10)
    begin
      entry[depth[3:0]] <= push_value;
      depth             <= depth + 5'h01;
    end
  end

endmodule // return_stack

// file: return_rotate_reset_ops.v
// Execution unit for no-op, software reset, returns, rotate-left and pointer steps.
//
// Contract
// - The software reset opcode resets every register except the instruction register and the cycle divider, and clears the reset-instruction flag.
// - Return from interrupt pops the return stack and loads the popped top into the PC.
// - Return from interrupt sets the global interrupt enable at bit 7 of interrupt control.
// - Return from interrupt takes two instruction cycles.
// - Return with literal writes its 8-bit immediate into the accumulator.
// - Return with literal pops the stack top into the PC and takes two instruction cycles.
// - Subroutine return, coded 0000 0000 0001 001s, pops into the PC in two cycles, no flags.
// - Rotate left moves bit n to bit n+1, bit 7 into carry and the old carry into bit 0.
// - Rotate left with destination bit 0 writes the accumulator and leaves the file cell.
// - Rotate left with destination bit 1 writes the result back into the file cell.
// - Pointer increment and decrement wrap within 16 bits and touch no status flag.
`include "return_rotate_reset_ops_regs.vh"

module return_rotate_reset_ops
(
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  output reg         device_reset_pulse,
  output reg         global_interrupt_enable
);

  localparam ST_IDLE   = 2'd0;
  localparam ST_FIRST  = 2'd1;
  localparam ST_SECOND = 2'd2;

  // Sorts an instruction word into its operation class.
  function [2:0] op_class;
    input [15:0] op;
    begin
      if (op == `OP_NOP)
        op_class = `CLS_NOP;
      else if (op == `OP_RESET)
        op_class = `CLS_RESET;
      else if (op == `OP_INT_RETURN)
        op_class = `CLS_INT_RETURN;
      else if ({1'b0, op[15:1]} == (`OP_RETURN_BASE >> 1))
        op_class = `CLS_RETURN;
      else if (op[15:8] == `OP_LIT_RETURN_HI)
        op_class = `CLS_LIT_RETURN;
      else if (op[15:10] == `OP_ROTATE_HI)
        op_class = `CLS_ROTATE;
      else if (op[15:2] == `OP_PTR_BASE)
        op_class = `CLS_PTR;
      else
        op_class = `CLS_OTHER;
    end
  endfunction

  // Returns take a second instruction cycle to refill the fetch path.
  function two_cycle;
    input [2:0] cls;
    begin
      two_cycle = (cls == `CLS_INT_RETURN) || (cls == `CLS_LIT_RETURN) || (cls == `CLS_RETURN);
    end
  endfunction

  reg  [1:0]  state;
  reg  [15:0] instr;
  reg  [7:0]  accum;
  reg         carry;
  reg         reset_instruction_flag;
  reg  [14:0] pc;
  reg  [15:0] ptr0;
  reg  [15:0] ptr1;
  reg  [6:0]  file_addr;
  reg  [7:0]  file_reg [0:`FILE_CELLS-1];
  reg  [15:0] cycles;
  reg  [31:0] next_readdata;
  integer     k;

  wire        cycle_tick;
  wire [14:0] stack_top;
  wire [4:0]  depth;
  wire [2:0]  cls = op_class(instr);
  wire        wr_now = write && !waitrequest;
  wire        finish = cycle_tick &&
                       ((state == ST_FIRST && !two_cycle(cls)) || state == ST_SECOND);
  wire        soft_reset = finish && (cls == `CLS_RESET);
  wire        do_pop = finish && two_cycle(cls);
  wire        do_rot = finish && (cls == `CLS_ROTATE);
  wire [6:0]  rot_addr = instr[6:0];
  wire [7:0]  rot_src = file_reg[rot_addr];
  wire [7:0]  rot_result = {rot_src[6:0], carry};
  wire        stack_push = wr_now && (address == `OFS_STACK);

  cycle_divider u_divider
  (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .cycle_tick (cycle_tick)
  );

  return_stack u_stack
  (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .clear      (soft_reset),
    .push       (stack_push),
    .pop        (do_pop),
    .push_value (writedata[14:0]),
    .stack_top  (stack_top),
    .depth      (depth)
  );

  // Instruction sequencer; a write to the instruction register starts one execution.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      instr <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (wr_now && address == `OFS_INSTR)
          begin
            instr <= writedata[15:0];
            state <= ST_FIRST;
          end
        end
        ST_FIRST:
        begin
          if (cycle_tick)
            state <= two_cycle(cls) ? ST_SECOND : ST_IDLE;
        end
        ST_SECOND:
        begin
          if (cycle_tick)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Bus slave: one wait cycle per access, and none taken while an instruction runs.
  // Stalling the bus during execution keeps software from racing the update of state.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end
    else if (waitrequest && (read || write) && state == ST_IDLE)
    begin
      waitrequest <= 1'b0;
      readdata    <= read ? next_readdata : 32'h00000000;
    end
    else
      waitrequest <= 1'b1;
  end

  // Read-back mux; unmapped offsets read as zero.
  always @*
  begin
    next_readdata = 32'h00000000;
    case (address)
      `OFS_INSTR:     next_readdata = {13'h0000, cls, instr};
      `OFS_ACCUM:     next_readdata = {24'h000000, accum};
      `OFS_STATUS:    next_readdata[`CARRY_BIT] = carry;
      `OFS_INTCTL:    next_readdata[`IRQ_ENABLE_BIT] = global_interrupt_enable;
      `OFS_PWRCTL:    next_readdata[`RESET_FLAG_BIT] = reset_instruction_flag;
      `OFS_PC:        next_readdata = {17'h00000, pc};
      `OFS_STACK:     next_readdata = {11'h000, depth, 1'b0, stack_top};
      `OFS_PTR0:      next_readdata = {16'h0000, ptr0};
      `OFS_PTR1:      next_readdata = {16'h0000, ptr1};
      `OFS_FILE_ADDR: next_readdata = {25'h0000000, file_addr};
      `OFS_FILE_DATA: next_readdata = {24'h000000, file_reg[file_addr]};
      `OFS_CYCLES:    next_readdata = {16'h0000, cycles};
      default:        next_readdata = 32'h00000000;
    endcase
  end

  // Accumulator and carry; the no-op and unknown opcodes leave both untouched.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      accum <= 8'h00;
      carry <= 1'b0;
    end
    else if (soft_reset)
    begin
      accum <= 8'h00;
      carry <= 1'b0;
    end
    else if (finish && cls == `CLS_LIT_RETURN)
      accum <= instr[7:0];
    else if (do_rot)
    begin
      carry <= rot_src[7];
      if (!instr[9])
        accum <= rot_result;
    end
    else if (wr_now && address == `OFS_ACCUM)
      accum <= writedata[7:0];
    else if (wr_now && address == `OFS_STATUS)
      carry <= writedata[`CARRY_BIT];
  end

  // Interrupt enable: hardware set by the interrupt return wins over a software clear.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      global_interrupt_enable <= `IRQ_ENABLE_RESET;
    else if (soft_reset)
      global_interrupt_enable <= `IRQ_ENABLE_RESET;
    else if (finish && cls == `CLS_INT_RETURN)
      global_interrupt_enable <= 1'b1;
    else if (wr_now && address == `OFS_INTCTL)
      global_interrupt_enable <= writedata[`IRQ_ENABLE_BIT];
  end

  // Reset-instruction flag is active low: only power-on reset or software sets it again.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reset_instruction_flag <= `RESET_FLAG_RESET;
    else if (soft_reset)
      reset_instruction_flag <= 1'b0;
    else if (wr_now && address == `OFS_PWRCTL)
      reset_instruction_flag <= writedata[`RESET_FLAG_BIT];
  end

  // Program counter; every return loads the popped stack top.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      pc <= 15'h0000;
    else if (soft_reset)
      pc <= 15'h0000;
    else if (do_pop)
      pc <= stack_top;
    else if (finish)
      pc <= pc + 15'h0001;
    else if (wr_now && address == `OFS_PC)
      pc <= writedata[14:0];
  end

  // Indirect pointers step with natural 16-bit wrap and leave carry alone.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ptr0 <= 16'h0000;
      ptr1 <= 16'h0000;
    end
    else if (soft_reset)
    begin
      ptr0 <= 16'h0000;
      ptr1 <= 16'h0000;
    end
    else if (finish && cls == `CLS_PTR)
    begin
      if (!instr[1])
        ptr0 <= instr[0] ? ptr0 - 16'h0001 : ptr0 + 16'h0001;
      else
        ptr1 <= instr[0] ? ptr1 - 16'h0001 : ptr1 + 16'h0001;
    end
    else if (wr_now && address == `OFS_PTR0)
      ptr0 <= writedata[15:0];
    else if (wr_now && address == `OFS_PTR1)
      ptr1 <= writedata[15:0];
  end

  // File cells; rotate writes back only when its destination bit is one.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      file_addr <= 7'h00;
      for (k = 0; k < `FILE_CELLS; k = k + 1)
        file_reg[k] <= 8'h00;
    end
    else if (soft_reset)
    begin
      file_addr <= 7'h00;
      for (k = 0; k < `FILE_CELLS; k = k + 1)
        file_reg[k] <= 8'h00;
    end
    else if (do_rot && instr[9])
      file_reg[rot_addr] <= rot_result;
    else if (wr_now && address == `OFS_FILE_DATA)
      file_reg[file_addr] <= writedata[7:0];
    else if (wr_now && address == `OFS_FILE_ADDR)
      file_addr <= writedata[6:0];
  end

  // Instruction-cycle counter lets software see that returns really cost two cycles.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cycles <= 16'h0000;
    else if (soft_reset)
      cycles <= 16'h0000;
    else if (cycle_tick && state != ST_IDLE)
      cycles <= cycles + 16'h0001;
  end

  // Reset request to the rest of the chip, one clock wide.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      device_reset_pulse <= 1'b0;
    else
      device_reset_pulse <= soft_reset;
  end

endmodule // return_rotate_reset_ops

// file: return_rotate_reset_ops_monitor.sv
// Port checker for the execution unit, bound to its top module.
`include "return_rotate_reset_ops_regs.vh"

module return_rotate_reset_ops_monitor
(
  input logic        clk_sys,
  input logic        reset_n,
  input logic [7:0]  address,
  input logic        read,
  input logic        write,
  input logic [31:0] writedata,
  input logic [31:0] readdata,
  input logic        waitrequest,
  input logic        device_reset_pulse,
  input logic        global_interrupt_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic [15:0] last_op;
  logic        prev_two;
  logic [7:0]  since;
  wire         any_acc = (read || write) && !waitrequest;
  wire         instr_acc = write && !waitrequest && address == `OFS_INSTR;
  wire         ictl_wr = write && !waitrequest && address == `OFS_INTCTL;
  wire [15:0]  op = writedata[15:0];
  wire         is_two = op == `OP_INT_RETURN || op[15:1] == 15'h0009 ||
                        op[15:8] == `OP_LIT_RETURN_HI;

  // Remember the last opcode and the gap since the last access; returns stall the bus longer.
  always @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      last_op  <= 16'h0000;
      prev_two <= 1'b0;
      since    <= 8'h00;
    end
    else
    begin
      if (instr_acc)
        last_op <= op;
      if (any_acc)
      begin
        since    <= 8'h00;
        prev_two <= instr_acc && is_two;
      end
      else if (since != 8'hff)
        since <= since + 8'h01;
    end

  a_pulse_cause: assert property (
    device_reset_pulse |-> last_op == `OP_RESET && !global_interrupt_enable)
    else $error("reset pulse without cause");
  a_pulse_single: assert property (device_reset_pulse |=> !device_reset_pulse)
    else $error("reset pulse too long");
  a_pulse_time: assert property (
    instr_acc && op == `OP_RESET |-> ##[2:12] device_reset_pulse)
    else $error("reset pulse missing");
  a_enable_rise: assert property (
    $rose(global_interrupt_enable) |->
    last_op == `OP_INT_RETURN || $past(ictl_wr && writedata[7]))
    else $error("enable rose without cause");
  a_enable_fall: assert property (
    $fell(global_interrupt_enable) |->
    last_op == `OP_RESET || $past(ictl_wr && !writedata[7]))
    else $error("enable fell without cause");
  // The opcode lands up to four clocks before the first tick, so the rise falls in a window.
  a_int_return_time: assert property (
    instr_acc && op == `OP_INT_RETURN && !global_interrupt_enable |=>
    !global_interrupt_enable [*5] ##[1:4] global_interrupt_enable)
    else $error("return from interrupt timing");
  a_nop_quiet: assert property (
    instr_acc && op == `OP_NOP |=>
    (!device_reset_pulse && $stable(global_interrupt_enable)) [*3])
    else $error("no-op acted");
  // Two instruction cycles plus the bus turnaround leave at least six idle clocks.
  a_two_cycle_stall: assert property (any_acc && prev_two |-> since >= 8'd6)
    else $error("return finished early");

  c_int_return: cover property (instr_acc && op == `OP_INT_RETURN);
  c_pulse: cover property (device_reset_pulse);
  c_two: cover property (any_acc && prev_two);
  c_enable_write: cover property (ictl_wr && writedata[7]);
endmodule // return_rotate_reset_ops_monitor

bind return_rotate_reset_ops return_rotate_reset_ops_monitor mon_u
(
  .clk_sys                 (clk_sys),
  .reset_n                 (reset_n),
  .address                 (address),
  .read                    (read),
  .write                   (write),
  .writedata               (writedata),
  .readdata                (readdata),
  .waitrequest             (waitrequest),
  .device_reset_pulse      (device_reset_pulse),
  .global_interrupt_enable (global_interrupt_enable)
);

// file: tb_return_rotate_reset_ops.sv
// Self-checking bench that runs each operation through the register bus.
`include "return_rotate_reset_ops_regs.vh"

module tb_return_rotate_reset_ops;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        device_reset_pulse;
  logic        global_interrupt_enable;
  int          n_mismatch = 0;
  int          checks = 0;
  int          n_pulse = 0;
  logic [7:0]  v;

  return_rotate_reset_ops dut_u
  (
    .clk_sys                 (clk_sys),
    .reset_n                 (reset_n),
    .address                 (address),
    .read                    (read),
    .write                   (write),
    .writedata               (writedata),
    .readdata                (readdata),
    .waitrequest             (waitrequest),
    .device_reset_pulse      (device_reset_pulse),
    .global_interrupt_enable (global_interrupt_enable)
  );

  // Free-running 25 MHz system clock.
  always #20 clk_sys = ~clk_sys;

  // Count reset pulses so the software reset can be seen from outside.
  always @(posedge clk_sys)
    if (device_reset_pulse === 1'b1)
      n_pulse++;

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // The request is held until waitrequest is sampled low, then dropped.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  // Reads wait out any running instruction, since the bus stalls meanwhile.
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    @(posedge clk_sys);
    address <= a;
    read    <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
    check(d & m, exp);
  endtask

  // The tests need well under a thousand clocks; a hang is cut short at five thousand.
  initial
  begin
    #200000;
    n_mismatch++;
    results();
  end

  initial
  begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rc(`OFS_PWRCTL, 32'h4, 32'h4);
    rc(`OFS_INTCTL, 32'hff, 32'h0);
    wr(`OFS_STACK, 32'h123);
    wr(`OFS_STACK, 32'h456);
    wr(`OFS_STATUS, 32'h1);
    wr(`OFS_INSTR, 32'h0c55);
    rc(`OFS_ACCUM, 32'hff, 32'h55);
    rc(`OFS_PC, 32'h7fff, 32'h456);
    rc(`OFS_STACK, 32'h1f7fff, 32'h10123);
    rc(`OFS_CYCLES, 32'hffff, 32'h2);
    rc(`OFS_INSTR, 32'h7ffff, 32'h30c55);
    wr(`OFS_INSTR, 32'h0013);
    rc(`OFS_PC, 32'h7fff, 32'h123);
    rc(`OFS_STACK, 32'h1f0000, 32'h0);
    rc(`OFS_STATUS, 32'h1, 32'h1);
    wr(`OFS_STACK, 32'h2a);
    wr(`OFS_INSTR, 32'h0012);
    rc(`OFS_PC, 32'h7fff, 32'h2a);
    wr(`OFS_STACK, 32'h77);
    wr(`OFS_INSTR, 32'h0009);
    rc(`OFS_PC, 32'h7fff, 32'h77);
    rc(`OFS_INTCTL, 32'h80, 32'h80);
    check({31'h0, global_interrupt_enable}, 32'h1);
    wr(`OFS_INSTR, 32'h0000);
    rc(`OFS_PC, 32'h7fff, 32'h78);
    rc(`OFS_ACCUM, 32'hff, 32'h55);
    rc(`OFS_CYCLES, 32'hffff, 32'h9);
    // An undecoded opcode behaves like the no-op.
    wr(`OFS_INSTR, 32'h0100);
    rc(`OFS_PC, 32'h7fff, 32'h79);
    rc(`OFS_CYCLES, 32'hffff, 32'ha);
    // Rotate each value to the accumulator, then in place with the new carry.
    wr(`OFS_FILE_ADDR, 32'h5);
    for (int i = 0; i < 2; i++)
    begin
      v = (i == 0) ? 8'he6 : 8'h41;
      wr(`OFS_FILE_DATA, {24'h0, v});
      wr(`OFS_STATUS, i);
      wr(`OFS_INSTR, 32'h3405);
      rc(`OFS_ACCUM, 32'hff, {24'h0, v[6:0], i[0]});
      rc(`OFS_STATUS, 32'h1, {31'h0, v[7]});
      rc(`OFS_FILE_DATA, 32'hff, {24'h0, v});
      wr(`OFS_INSTR, 32'h3605);
      rc(`OFS_FILE_DATA, 32'hff, {24'h0, v[6:0], v[7]});
    end
    // Carry is set first so that a pointer step that touched it would show.
    wr(`OFS_STATUS, 32'h1);
    wr(`OFS_PTR0, 32'hffff);
    wr(`OFS_INSTR, 32'h0020);
    rc(`OFS_PTR0, 32'hffff, 32'h0);
    wr(`OFS_INSTR, 32'h0021);
    rc(`OFS_PTR0, 32'hffff, 32'hffff);
    wr(`OFS_PTR1, 32'h0);
    wr(`OFS_INSTR, 32'h0023);
    rc(`OFS_PTR1, 32'hffff, 32'hffff);
    wr(`OFS_INSTR, 32'h0022);
    rc(`OFS_PTR1, 32'hffff, 32'h0);
    rc(`OFS_STATUS, 32'h1, 32'h1);
    wr(`OFS_INSTR, 32'h0001);
    rc(`OFS_PWRCTL, 32'h4, 32'h0);
    rc(`OFS_ACCUM, 32'hff, 32'h0);
    rc(`OFS_STACK, 32'h1f0000, 32'h0);
    check({31'h0, global_interrupt_enable}, 32'h0);
    check(n_pulse, 32'h1);
    rc(`OFS_PC, 32'h7fff, 32'h0);
    rc(`OFS_PTR0, 32'hffff, 32'h0);
    rc(`OFS_CYCLES, 32'hffff, 32'h0);
    rc(`OFS_FILE_DATA, 32'hff, 32'h0);
    rc(8'h40, 32'hffffffff, 32'h0);
    wr(`OFS_PWRCTL, 32'h4);
    rc(`OFS_PWRCTL, 32'h4, 32'h4);
    // Software may also set and clear the interrupt enable directly.
    wr(`OFS_INTCTL, 32'h80);
    rc(`OFS_INTCTL, 32'h80, 32'h80);
    check({31'h0, global_interrupt_enable}, 32'h1);
    wr(`OFS_INTCTL, 32'h0);
    rc(`OFS_INTCTL, 32'h80, 32'h0);
    check({31'h0, global_interrupt_enable}, 32'h0);
    results();
  end
endmodule // tb_return_rotate_reset_ops
